// ===== inc/mcs_pkg.sv
// package for the modem control, status, scratch and interrupt mask bank
package mcs_pkg;
   // register indices on the host register port
   localparam logic [2:0] MCS_IDX_MASK    = 3'h1;
   localparam logic [2:0] MCS_IDX_CTL     = 3'h4;
   localparam logic [2:0] MCS_IDX_STATUS  = 3'h6;
   localparam logic [2:0] MCS_IDX_SCRATCH = 3'h7;

   // values after reset
   localparam logic [7:0] MCS_CTL_RST     = 8'h00;
   localparam logic [7:0] MCS_MASK_RST    = 8'h00;
   localparam logic [7:0] MCS_SCRATCH_RST = 8'h00;

   // modem_line_control fields
   localparam int MCS_CTL_DTR    = 0;
   localparam int MCS_CTL_RTS    = 1;
   localparam int MCS_CTL_THREN  = 2;
   localparam int MCS_CTL_LOOP   = 4;
   localparam int MCS_CTL_XONANY = 5;
   localparam int MCS_CTL_IRDA   = 6;
   localparam int MCS_CTL_DIV4   = 7;
   // bits writable only with the enhanced-function enable
   localparam logic [7:0] MCS_CTL_LOCKED  = 8'he4;
   // reserved bit 3 never stores
   localparam logic [7:0] MCS_CTL_STORED  = 8'hf7;

   // interrupt_mask fields
   localparam int MCS_MSK_RHR   = 0;
   localparam int MCS_MSK_THR   = 1;
   localparam int MCS_MSK_RLS   = 2;
   localparam int MCS_MSK_MODEM = 3;
   localparam int MCS_MSK_SLEEP = 4;
   localparam int MCS_MSK_XOFF  = 5;
   localparam int MCS_MSK_RTS   = 6;
   localparam int MCS_MSK_CTS   = 7;
   localparam logic [7:0] MCS_MSK_LOCKED = 8'hf0;

   // modem line index: 0 cts, 1 dsr, 2 ri, 3 cd
   localparam int MCS_LN_CTS = 0;
   localparam int MCS_LN_DSR = 1;
   localparam int MCS_LN_RI  = 2;
   localparam int MCS_LN_CD  = 3;

   // active-low modem inputs from the far side
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } mcs_modem_in_t;

   // interrupt sources from the rest of the uart
   typedef struct packed {
      logic cts_rise;
      logic rts_rise;
      logic xoff;
      logic rls_err;
      logic thr_event;
      logic thr_ack;
      logic rx_holding_reg;
   } mcs_irq_src_t;
endpackage : mcs_pkg

// ===== rtl/mcs_bank.sv
// modem control, modem status, scratch and interrupt mask registers
//
// Behaviour
// - loopback routes control bits 1:0 into status 4,5 and tx back to rx
// - control bit 2 enables flow threshold and fifo trigger registers
// - control bit 1 drives rts low when 1; in loopback sets status bit 4
// - automatic rts flow control overrides the manual rts bit
// - with pin 5 as dtr, control bit 0 drives dtr; pin level ignored
// - control bits 7:5 and 2 write only with enhanced enable
// - with pin 6 as cd, status bit 7 is inverse of cd input
// - with pin 7 as ri, status bit 6 is inverse of ri input
// - with pin 4 as dsr, status bit 5 is inverse of dsr input
// - status bit 4 is inverse of the cts input outside loopback
// - status bits 3,1,0 latch on cd, dsr, cts change; clear on read
// - status bit 2 latches on ri pin rising; clears on read
// - 8-bit scratch register, free to write and read back
// - interrupt output asserts on any enabled interrupt condition
// - mask bits 7,6 enable cts and rts change interrupts; reset 0
// - mask bit 5 enables xoff or special character interrupt; reset 0
// - mask bit 4 selects sleep mode; reset 0
// - mask bit 3 enables modem status interrupt; reset 0
// - mask bit 2 enables receiver line status interrupt; reset 0
// - mask bits 1,0 enable transmit and receive holding interrupts
// - mask bits 7:4 write only with enhanced enable
// - re-enabling transmit holding interrupt raises no new interrupt
`timescale 1ns/1ps
module mcs_bank
   import mcs_pkg::*;
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   // host register port
   input  wire logic [2:0]    reg_addr_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   input  wire logic [7:0]    reg_wdata_i,
   output logic      [7:0]    reg_rdata_o,
   // configuration from other registers
   input  wire logic          enh_en_i,
   input  wire logic          modem_pins_i,
   input  wire logic          pin5_level_i,
   input  wire logic          auto_rts_en_i,
   input  wire logic          auto_rts_n_i,
   // modem lines and serial path
   input  wire mcs_modem_in_t modem_i,
   output logic               rts_n_o,
   output logic               dtr_n_o,
   input  wire logic          tx_serial_i,
   input  wire logic          rx_pin_i,
   output logic               rx_serial_o,
   // controls to the rest of the uart
   output logic               thr_regs_en_o,
   output logic               xon_any_o,
   output logic               irda_o,
   output logic               clk_div4_o,
   output logic               sleep_o,
   // interrupts
   input  wire mcs_irq_src_t  irq_src_i,
   output logic               irq_n_o
);
   logic [7:0] ctl_q;
   logic [7:0] mask_q;
   logic [7:0] scratch_q;
   logic [3:0] delta_q;
   logic [3:0] line_prev_q;
   logic       thr_pend_q;
   logic [3:0] line_act;
   logic [3:0] delta_set;
   logic [7:0] status;
   logic       loop;
   logic       wr_ctl;
   logic       wr_mask;
   logic       rd_status;
   logic       irq_any;

   assign loop      = ctl_q[MCS_CTL_LOOP];
   assign wr_ctl    = reg_wr_i && (reg_addr_i == MCS_IDX_CTL);
   assign wr_mask   = reg_wr_i && (reg_addr_i == MCS_IDX_MASK);
   assign rd_status = reg_rd_i && (reg_addr_i == MCS_IDX_STATUS);

   // modem_line_control; locked bits keep their value without enable
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q <= MCS_CTL_RST;
      end else if (wr_ctl) begin
         if (enh_en_i) begin
            ctl_q <= reg_wdata_i & MCS_CTL_STORED;
         end else begin
            ctl_q <= ((reg_wdata_i & ~MCS_CTL_LOCKED)
                      | (ctl_q & MCS_CTL_LOCKED)) & MCS_CTL_STORED;
         end
      end
   end

   // interrupt_mask; upper nibble locked without enable
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_q <= MCS_MASK_RST;
      end else if (wr_mask) begin
         if (enh_en_i) begin
            mask_q <= reg_wdata_i;
         end else begin
            mask_q <= (reg_wdata_i & ~MCS_MSK_LOCKED)
                      | (mask_q & MCS_MSK_LOCKED);
         end
      end
   end

   // scratch_store has no side effect anywhere
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scratch_q <= MCS_SCRATCH_RST;
      end else if (reg_wr_i && (reg_addr_i == MCS_IDX_SCRATCH)) begin
         scratch_q <= reg_wdata_i;
      end
   end

   // active-high line states; loopback replaces cts and dsr
   always_comb begin
      line_act[MCS_LN_CTS] = loop ? ctl_q[MCS_CTL_RTS]
                                  : ~modem_i.cts_n;
      line_act[MCS_LN_DSR] = loop ? ctl_q[MCS_CTL_DTR]
                                  : (modem_pins_i & ~modem_i.dsr_n);
      line_act[MCS_LN_RI]  = modem_pins_i & ~modem_i.ri_n;
      line_act[MCS_LN_CD]  = modem_pins_i & ~modem_i.cd_n;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_prev_q <= 4'h0;
      end else begin
         line_prev_q <= line_act;
      end
   end

   // ri counts only the pin going low to high, i.e. active falling
   always_comb begin
      delta_set             = line_act ^ line_prev_q;
      delta_set[MCS_LN_RI]  = line_prev_q[MCS_LN_RI]
                              & ~line_act[MCS_LN_RI];
   end

   // change bits: a change in the read cycle survives the clear
   for (genvar i = 0; i < 4; i++) begin : g_delta
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            delta_q[i] <= 1'b0;
         end else if (delta_set[i]) begin
            delta_q[i] <= 1'b1;
         end else if (rd_status) begin
            delta_q[i] <= 1'b0;
         end
      end
   end

   assign status = {line_act[MCS_LN_CD], line_act[MCS_LN_RI],
                    line_act[MCS_LN_DSR], line_act[MCS_LN_CTS],
                    delta_q[MCS_LN_CD], delta_q[MCS_LN_RI],
                    delta_q[MCS_LN_DSR], delta_q[MCS_LN_CTS]};

   // read data registered; unmapped indices read zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            MCS_IDX_CTL:     reg_rdata_o <= ctl_q;
            MCS_IDX_MASK:    reg_rdata_o <= mask_q;
            MCS_IDX_STATUS:  reg_rdata_o <= status;
            MCS_IDX_SCRATCH: reg_rdata_o <= scratch_q;
            default:         reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // pins held inactive in loopback so the far side sees no change
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rts_n_o <= 1'b1;
         dtr_n_o <= 1'b1;
      end else begin
         if (loop) begin
            rts_n_o <= 1'b1;
         end else if (auto_rts_en_i) begin
            rts_n_o <= auto_rts_n_i;
         end else begin
            rts_n_o <= ~ctl_q[MCS_CTL_RTS];
         end
         if (loop) begin
            dtr_n_o <= 1'b1;
         end else if (modem_pins_i) begin
            dtr_n_o <= ~ctl_q[MCS_CTL_DTR];
         end else begin
            dtr_n_o <= pin5_level_i;
         end
      end
   end

   // serial return path; idle-high line in loopback comes from tx
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_serial_o <= 1'b1;
      end else begin
         rx_serial_o <= loop ? tx_serial_i : rx_pin_i;
      end
   end

   // controls out
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thr_regs_en_o <= 1'b0;
         xon_any_o     <= 1'b0;
         irda_o        <= 1'b0;
         clk_div4_o    <= 1'b0;
         sleep_o       <= 1'b0;
      end else begin
         thr_regs_en_o <= ctl_q[MCS_CTL_THREN];
         xon_any_o     <= ctl_q[MCS_CTL_XONANY];
         irda_o        <= ctl_q[MCS_CTL_IRDA];
         clk_div4_o    <= ctl_q[MCS_CTL_DIV4];
         sleep_o       <= mask_q[MCS_MSK_SLEEP];
      end
   end

   // thr interrupt is an edge-made pending bit, not the level, so a
   // second enable cannot invent an interrupt; event beats ack
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thr_pend_q <= 1'b0;
      end else if (irq_src_i.thr_event) begin
         thr_pend_q <= 1'b1;
      end else if (irq_src_i.thr_ack) begin
         thr_pend_q <= 1'b0;
      end
   end

   assign irq_any =
      (mask_q[MCS_MSK_RHR]   & irq_src_i.rx_holding_reg)
    | (mask_q[MCS_MSK_THR]   & thr_pend_q)
    | (mask_q[MCS_MSK_RLS]   & irq_src_i.rls_err)
    | (mask_q[MCS_MSK_MODEM] & (|delta_q))
    | (mask_q[MCS_MSK_XOFF]  & irq_src_i.xoff)
    | (mask_q[MCS_MSK_RTS]   & irq_src_i.rts_rise)
    | (mask_q[MCS_MSK_CTS]   & irq_src_i.cts_rise);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_o <= 1'b1;
      end else begin
         irq_n_o <= ~irq_any;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   ctl_lock_a: assert property (
      wr_ctl && !enh_en_i |=>
         (ctl_q & MCS_CTL_LOCKED) == ($past(ctl_q) & MCS_CTL_LOCKED))
      else $error("locked control bits changed");

   mask_lock_a: assert property (
      wr_mask && !enh_en_i |=>
         (mask_q & MCS_MSK_LOCKED) == ($past(mask_q) & MCS_MSK_LOCKED))
      else $error("locked mask bits changed");

   cts_status_a: assert property (
      !loop |-> status[4] == ~modem_i.cts_n)
      else $error("cts status not inverse of pin");

   loop_status_a: assert property (
      loop |-> status[5:4] == {ctl_q[MCS_CTL_DTR], ctl_q[MCS_CTL_RTS]})
      else $error("loopback status wrong");

   rts_manual_a: assert property (
      !loop && !auto_rts_en_i |=> rts_n_o == ~$past(ctl_q[MCS_CTL_RTS]))
      else $error("rts pin not following control");

   rts_auto_a: assert property (
      !loop && auto_rts_en_i |=> rts_n_o == $past(auto_rts_n_i))
      else $error("auto rts not driving pin");

   dtr_pin_a: assert property (
      !loop && modem_pins_i |=> dtr_n_o == ~$past(ctl_q[MCS_CTL_DTR]))
      else $error("dtr pin not following control");

   ri_edge_a: assert property (
      !delta_q[MCS_LN_RI] && line_prev_q[MCS_LN_RI]
         && !line_act[MCS_LN_RI] |=> delta_q[MCS_LN_RI])
      else $error("ri edge missed");

   delta_clear_a: assert property (
      rd_status && delta_set == 4'h0 |=> delta_q == 4'h0)
      else $error("change bits not cleared on read");

   cts_change_a: assert property (
      $changed(line_act[MCS_LN_CTS]) |=> delta_q[MCS_LN_CTS])
      else $error("cts change missed");

   modem_irq_a: assert property (
      mask_q[MCS_MSK_MODEM] && (|delta_q) |=> !irq_n_o)
      else $error("modem interrupt not raised");

   irq_idle_a: assert property (
      mask_q == 8'h00 |=> irq_n_o)
      else $error("interrupt with all sources masked");

   thr_reenable_a: assert property (
      !thr_pend_q && !irq_src_i.thr_event
         && (mask_q & ~(8'h01 << MCS_MSK_THR)) == 8'h00 |=> irq_n_o)
      else $error("thr interrupt without event");
endmodule : mcs_bank

// ===== test/mcs_modem_peer.sv
// far-side modem model: drives the active-low status lines
`timescale 1ns/1ps
module mcs_modem_peer
   import mcs_pkg::*;
(
   // clock
   input  wire logic          clk_i,
   // lines from the device
   input  wire logic          rts_n_i,
   input  wire logic          dtr_n_i,
   // lines to the device
   output mcs_modem_in_t      modem_o
);
   logic [1:0] seen_q;

   // all lines idle high, like an unplugged data set
   initial begin
      modem_o = 4'hf;
   end

   // lines move just after a falling edge, never on the sampling edge
   task automatic set_lines(input logic [3:0] lv);
      @(negedge clk_i);
      modem_o = lv;
   endtask : set_lines

   // requests are only watched; this peer never answers them
   always_ff @(posedge clk_i) begin
      seen_q <= {rts_n_i, dtr_n_i};
   end
endmodule : mcs_modem_peer

// ===== test/tb.sv
// self-checking bench for the modem control and status bank
`timescale 1ns/1ps
module tb;
   import mcs_pkg::*;
   logic          clk_i, rst_n_i, reg_wr_i, reg_rd_i;
   logic [2:0]    reg_addr_i;
   logic [7:0]    reg_wdata_i, reg_rdata_o;
   logic          enh_en_i, modem_pins_i, pin5_level_i;
   logic          auto_rts_en_i, auto_rts_n_i, tx_serial_i, rx_pin_i;
   logic          rts_n_o, dtr_n_o, rx_serial_o, irq_n_o, sleep_o;
   logic          thr_regs_en_o, xon_any_o, irda_o, clk_div4_o;
   mcs_modem_in_t modem_i;
   mcs_irq_src_t  irq_src_i;
   int            n_mismatch, total_checks;
   int            mb[5] = '{0, 2, 5, 6, 7};
   int            sb[5] = '{0, 3, 4, 5, 6};

   mcs_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .enh_en_i(enh_en_i), .modem_pins_i(modem_pins_i),
      .pin5_level_i(pin5_level_i), .auto_rts_en_i(auto_rts_en_i),
      .auto_rts_n_i(auto_rts_n_i), .modem_i(modem_i), .rts_n_o(rts_n_o),
      .dtr_n_o(dtr_n_o), .tx_serial_i(tx_serial_i), .rx_pin_i(rx_pin_i),
      .rx_serial_o(rx_serial_o), .thr_regs_en_o(thr_regs_en_o),
      .xon_any_o(xon_any_o), .irda_o(irda_o), .clk_div4_o(clk_div4_o),
      .sleep_o(sleep_o), .irq_src_i(irq_src_i), .irq_n_o(irq_n_o));

   mcs_modem_peer u_peer (.clk_i(clk_i), .rts_n_i(rts_n_o),
      .dtr_n_i(dtr_n_o), .modem_o(modem_i));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask : wr

   // data is due one edge after the read strobe is taken
   task automatic rd(input logic [2:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      chk(reg_rdata_o & m, e);
   endtask : rd

   // pins packed as rts, dtr, rx, irq
   task automatic pins(input logic [7:0] e);
      cyc(2);
      chk({4'h0, rts_n_o, dtr_n_o, rx_serial_o, irq_n_o}, e);
   endtask : pins

   // hang guard, far above the longest sequence
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      {enh_en_i, auto_rts_en_i, irq_src_i} = '0;
      {modem_pins_i, pin5_level_i, auto_rts_n_i} = 3'h7;
      {tx_serial_i, rx_pin_i} = 2'h3;
      cyc(3);
      rst_n_i = 1'b1;
      pins(8'h0f);
      rd(MCS_IDX_MASK, 8'hff, 8'h00);
      rd(MCS_IDX_CTL, 8'hff, 8'h00);
      rd(MCS_IDX_STATUS, 8'hf0, 8'h00);
      rd(MCS_IDX_STATUS, 8'hff, 8'h00);
      wr(MCS_IDX_SCRATCH, 8'ha5);
      rd(MCS_IDX_SCRATCH, 8'hff, 8'ha5);
      wr(MCS_IDX_SCRATCH, 8'h5a);
      wr(3'h0, 8'hff);
      rd(3'h0, 8'hff, 8'h00);
      rd(MCS_IDX_SCRATCH, 8'hff, 8'h5a);
      // locked bits keep their value, loopback comes on
      wr(MCS_IDX_CTL, 8'hff);
      rd(MCS_IDX_CTL, 8'hff, 8'h13);
      rd(MCS_IDX_STATUS, 8'h30, 8'h30);
      pins(8'h0f);
      tx_serial_i = 1'b0;
      pins(8'h0d);
      tx_serial_i = 1'b1;
      wr(MCS_IDX_MASK, 8'hff);
      rd(MCS_IDX_MASK, 8'hff, 8'h0f);
      chk({7'h0, sleep_o}, 8'h00);
      enh_en_i = 1'b1;
      wr(MCS_IDX_MASK, 8'h10);
      rd(MCS_IDX_MASK, 8'hff, 8'h10);
      chk({7'h0, sleep_o}, 8'h01);
      wr(MCS_IDX_CTL, 8'he7);
      rd(MCS_IDX_CTL, 8'hff, 8'he7);
      chk({4'h0, clk_div4_o, irda_o, xon_any_o, thr_regs_en_o}, 8'h0f);
      pins(8'h03);
      pin5_level_i = 1'b0;
      wr(MCS_IDX_CTL, 8'he4);
      pins(8'h0f);
      rx_pin_i = 1'b0;
      {auto_rts_en_i, auto_rts_n_i} = 2'h2;
      pins(8'h05);
      {auto_rts_en_i, rx_pin_i} = 2'h1;
      // leaving loopback drops looped cts and dsr, itself a change
      rd(MCS_IDX_STATUS, 8'hff, 8'h03);
      // modem line changes with the modem interrupt enabled
      wr(MCS_IDX_MASK, 8'h08);
      u_peer.set_lines(4'he);
      pins(8'h0e);
      rd(MCS_IDX_STATUS, 8'hff, 8'h11);
      pins(8'h0f);
      rd(MCS_IDX_STATUS, 8'hff, 8'h10);
      u_peer.set_lines(4'hc);
      rd(MCS_IDX_STATUS, 8'hff, 8'h32);
      u_peer.set_lines(4'h4);
      rd(MCS_IDX_STATUS, 8'hff, 8'hb8);
      rd(MCS_IDX_STATUS, 8'hff, 8'hb0);
      u_peer.set_lines(4'h0);
      rd(MCS_IDX_STATUS, 8'hff, 8'hf0);
      u_peer.set_lines(4'h4);
      rd(MCS_IDX_STATUS, 8'hff, 8'hb4);
      rd(MCS_IDX_STATUS, 8'hff, 8'hb0);
      wr(MCS_IDX_MASK, 8'h00);
      u_peer.set_lines(4'h5);
      pins(8'h0f);
      rd(MCS_IDX_STATUS, 8'h0f, 8'h01);
      // each level source against its own enable and all others
      for (int i = 0; i < 5; i++) begin
         wr(MCS_IDX_MASK, 8'h01 << mb[i]);
         irq_src_i = 7'h01 << sb[i];
         pins(8'h0e);
         wr(MCS_IDX_MASK, ~(8'h01 << mb[i]));
         pins(8'h0f);
         irq_src_i = '0;
      end
      // transmit holding: pending set by event, cleared by ack
      wr(MCS_IDX_MASK, 8'h02);
      irq_src_i = 7'h04;
      cyc(1);
      irq_src_i = 7'h00;
      pins(8'h0e);
      irq_src_i = 7'h02;
      cyc(1);
      irq_src_i = 7'h00;
      pins(8'h0f);
      wr(MCS_IDX_MASK, 8'h00);
      wr(MCS_IDX_MASK, 8'h02);
      pins(8'h0f);
      // loopback: rts bit to status 4, dtr bit to status 5
      wr(MCS_IDX_CTL, 8'h11);
      rd(MCS_IDX_STATUS, 8'h30, 8'h20);
      wr(MCS_IDX_CTL, 8'h12);
      rd(MCS_IDX_STATUS, 8'h30, 8'h10);
      wr(MCS_IDX_CTL, 8'h01);
      pins(8'h0b);
      rd(MCS_IDX_STATUS, 8'he0, 8'ha0);
      // pins 4..7 as plain pins: dtr from pin level, status gated
      modem_pins_i = 1'b0;
      pin5_level_i = 1'b1;
      pins(8'h0f);
      rd(MCS_IDX_STATUS, 8'he0, 8'h00);
      // reset in mid-run brings every register back
      rst_n_i = 1'b0;
      cyc(3);
      rst_n_i = 1'b1;
      pins(8'h0f);
      rd(MCS_IDX_CTL, 8'hff, MCS_CTL_RST);
      rd(MCS_IDX_MASK, 8'hff, MCS_MASK_RST);
      rd(MCS_IDX_SCRATCH, 8'hff, MCS_SCRATCH_RST);
      end_sim();
   end
endmodule : tb
